// >>> inc/frame_decoder_pkg.sv
package frame_decoder_pkg;
    // =====================================================
    // register word offsets (avalon word addressing)
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_SEQ       = 8'h01;
    localparam logic [7:0] OFS_CLIPBASE  = 8'h02;
    localparam logic [7:0] OFS_STATUS    = 8'h03;
    localparam logic [7:0] OFS_PERIOD    = 8'h04;
    localparam logic [7:0] OFS_RATE      = 8'h05;
    localparam logic [7:0] OFS_CLIPEND   = 8'h40;
    localparam logic [7:0] OFS_MEM       = 8'h80;
    localparam int         MEM_BYTES     = 100;
    localparam int         CLIP_SLOTS    = 16;
    // =====================================================
    // field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_FAST  = 1;
    localparam int EXT_BIT    = 7;
    localparam int RATE_HERE  = 2;
    localparam int RATE_HI    = 1;
    localparam int CLIP_HI    = 0;
    // =====================================================
    // reset values and fixed figures
    localparam logic [8:0]  RATE_RESET   = 9'h000;
    localparam logic [19:0] PERIOD_RESET = 20'h00000;
    localparam logic [6:0]  CLIPBASE_RST = 7'h00;
    localparam logic [9:0]  MIN_RATE_HZ  = 10'h019;
    localparam logic [19:0] US_PER_S     = 20'hf4240;
    localparam logic [2:0]  SILENT_DUR   = 3'h2;
    localparam int          DIV_STEPS    = 20;
    // =====================================================
    // timing: shortest timebase, all others are power-of-two multiples
    localparam int CLK_PERIOD_NS = 100;
    localparam int BASE_TB_US    = 1360;
    localparam int BASE_TB_CYC   = (BASE_TB_US * 1000) / CLK_PERIOD_NS;
    // =====================================================
    typedef struct packed {
        logic [1:0] gain;
        logic [1:0] tbase;
        logic [3:0] clipIdx;
        logic [3:0] loopCode;
        logic       rateHere;
        logic [8:0] rateCode;
    } frame_t;
endpackage : frame_decoder_pkg

// >>> verilog/timebase_ticker.sv
`timescale 1ns/10ps
// =====================================================
// timebase tick generator
module timebase_ticker #(
    parameter int BASE_CYC = frame_decoder_pkg::BASE_TB_CYC
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       run,
    input  wire logic       fast,
    input  wire logic [1:0] sel,
    output logic            tick
);
    logic [23:0] count;
    logic [2:0]  shift;
    logic [23:0] limit;
    // slow codes are 4x,16x,32x,64x base; fast codes 1x,4x,16x,32x
    assign shift = fast ? (sel == 2'h0 ? 3'h0 : sel == 2'h1 ? 3'h2 : sel == 2'h2 ? 3'h4 : 3'h5)
                        : (sel == 2'h0 ? 3'h2 : sel == 2'h1 ? 3'h4 : sel == 2'h2 ? 3'h5 : 3'h6);
    assign limit = 24'(BASE_CYC) << shift;
    assign tick  = run && (count == limit - 24'h1);
    // counter restarts whenever a point is loaded, so each point gets whole timebases
    always_ff @(posedge clk)
    begin
        if (srst || !run || tick)
            count <= 24'h0;
        else
            count <= count + 24'h1;
    end
endmodule : timebase_ticker

// >>> verilog/level_shaper.sv
`timescale 1ns/10ps
// =====================================================
// ramp or step of the drive level over a number of timebases
module level_shaper (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       load,
    input  wire logic [7:0] target,
    input  wire logic       ramp,
    input  wire logic [2:0] dur,
    input  wire logic       tick,
    output logic [7:0]      level,
    output logic            done
);
    logic [2:0] left;
    logic [7:0] goal;
    logic [8:0] diff;
    logic [8:0] stepv;
    // signed share of the remaining distance for one tick
    function automatic logic [8:0] share(input logic [8:0] d, input logic [2:0] n);
        logic signed [8:0] q;
        q = $signed(d) / $signed({6'h0, n});
        return q;
    endfunction : share
    assign diff  = {1'b0, goal} - {1'b0, level};
    assign stepv = share(diff, left);
    assign done  = (left == 3'h0);
    // ramp reaches goal exactly on the last tick, avoiding drift
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            level <= 8'h00;
            left  <= 3'h0;
            goal  <= 8'h00;
        end
        else if (load)
        begin
            goal <= target;
            left <= dur;
            if (!ramp || dur == 3'h0)
                level <= target;
        end
        else if (tick && !done)
        begin
            left  <= left - 3'h1;
            level <= 8'(({1'b0, level} + stepv));
        end
    end
endmodule : level_shaper

// >>> verilog/frame_sequence_decoder.sv
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
module frame_sequence_decoder #(
    parameter int BASE_CYC = frame_decoder_pkg::BASE_TB_CYC
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic [8:0]  trackedRate,
    output logic [7:0]       driveLevel,
    output logic [8:0]       driveRateCode,
    output logic             playing
);
    typedef enum {IDLE, FETCH1, FETCH2, FETCH3, SETUP, DIVIDE, LOAD, POINT, WAIT} state_t;
    // =====================================================
    // storage and control state
    state_t                  state;
    logic [7:0]              mem [0:frame_decoder_pkg::MEM_BYTES-1];
    logic [6:0]              clipEnd [0:frame_decoder_pkg::CLIP_SLOTS-1];
    logic                    fastStepUnitSelect;
    logic                    startReq;
    logic [6:0]              seqStart;
    logic [6:0]              seqEnd;
    logic [6:0]              clipBase;
    logic                    formatError;
    logic [6:0]              ptr;
    logic [6:0]              pointPtr;
    logic [3:0]              loopLeft;
    frame_decoder_pkg::frame_t frame;
    logic [19:0]             activePeriodReadback;
    logic [19:0]             quot;
    logic [10:0]             rem;
    logic [10:0]             divisor;
    logic [4:0]              divCount;
    logic [7:0]              pointTarget;
    // =====================================================
    // decode helpers
    function automatic logic [6:0] first_addr(input logic [3:0] idx, input logic [6:0] base,
                                              input logic [6:0] prevEnd);
        return (idx == 4'h1) ? base : 7'(prevEnd + 7'h1);
    endfunction : first_addr
    function automatic logic [9:0] rate_hz(input logic [8:0] code);
        logic [9:0] hz;
        hz = {code, 1'b0};
        return (hz < frame_decoder_pkg::MIN_RATE_HZ) ? frame_decoder_pkg::MIN_RATE_HZ : hz;
    endfunction : rate_hz
    // =====================================================
    // bus decode
    wire        busReq    = (read || write) && waitrequest;
    wire        wrNow     = write && !waitrequest;
    wire        inMem     = (address >= frame_decoder_pkg::OFS_MEM) &&
                            (address < frame_decoder_pkg::OFS_MEM + 8'(frame_decoder_pkg::MEM_BYTES));
    wire        inClip    = (address >= frame_decoder_pkg::OFS_CLIPEND) &&
                            (address < frame_decoder_pkg::OFS_CLIPEND + 8'h10);
    wire [6:0]  memOff    = 7'(address - frame_decoder_pkg::OFS_MEM);
    wire [3:0]  clipOff   = 4'(address - frame_decoder_pkg::OFS_CLIPEND);
    wire [31:0] readMux   =
        (address == frame_decoder_pkg::OFS_CTRL)     ? {30'h0, fastStepUnitSelect, 1'b0} :
        (address == frame_decoder_pkg::OFS_SEQ)      ? {17'h0, seqEnd, 1'b0, seqStart} :
        (address == frame_decoder_pkg::OFS_CLIPBASE) ? {25'h0, clipBase} :
        (address == frame_decoder_pkg::OFS_STATUS)   ? {18'h0, loopLeft, frame.clipIdx,
                                                        4'h0, formatError, playing} :
        (address == frame_decoder_pkg::OFS_PERIOD)   ? {12'h0, activePeriodReadback} :
        (address == frame_decoder_pkg::OFS_RATE)     ? {23'h0, driveRateCode} :
        inClip ? {25'h0, clipEnd[clipOff]} :
        inMem  ? {24'h0, mem[memOff]} : 32'h0;
    // =====================================================
    // frame and clip decode
    wire [7:0]  curByte   = mem[ptr];
    wire        extFlag   = curByte[frame_decoder_pkg::EXT_BIT];
    wire [6:0]  clipFirst = first_addr(frame.clipIdx, clipBase,
                                       clipEnd[4'(frame.clipIdx - 4'h1)]);
    wire [6:0]  clipLast  = clipEnd[frame.clipIdx];
    wire [7:0]  pointByte = mem[pointPtr];
    wire        silent    = (frame.clipIdx == 4'h0);
    wire        seqDone   = (ptr == 7'(seqEnd + 7'h1));
    wire [11:0] remShift  = {rem, quot[19]};
    wire        fits      = remShift >= {1'b0, divisor};
    wire        tick;
    wire [7:0]  shapedLevel;
    wire        shapeDone;
    wire        startPoint = (state == POINT);
    // =====================================================
    // avalon slave: answer one cycle after the request is seen
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0;
        end
        else
        begin
            waitrequest <= !busReq;
            if (busReq && read)
                readdata <= readMux;
        end
    end
    // =====================================================
    // software writes; a start while busy is ignored
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            fastStepUnitSelect <= 1'b0;
            startReq           <= 1'b0;
            seqStart           <= 7'h0;
            seqEnd             <= 7'h0;
            clipBase           <= frame_decoder_pkg::CLIPBASE_RST;
        end
        else
        begin
            startReq <= wrNow && address == frame_decoder_pkg::OFS_CTRL &&
                        writedata[frame_decoder_pkg::CTRL_START];
            if (wrNow && address == frame_decoder_pkg::OFS_CTRL)
                fastStepUnitSelect <= writedata[frame_decoder_pkg::CTRL_FAST];
            if (wrNow && address == frame_decoder_pkg::OFS_SEQ)
            begin
                seqStart <= writedata[6:0];
                seqEnd   <= writedata[14:8];
            end
            if (wrNow && address == frame_decoder_pkg::OFS_CLIPBASE)
                clipBase <= writedata[6:0];
        end
    end
    // memory and clip table have no reset: contents are loaded by software
    always_ff @(posedge clk)
    begin
        if (wrNow && inMem)
            mem[memOff] <= writedata[7:0];
        if (wrNow && inClip)
            clipEnd[clipOff] <= writedata[6:0];
    end
    // =====================================================
    // frame fetch and playback sequencer
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state         <= IDLE;
            ptr           <= 7'h0;
            pointPtr      <= 7'h0;
            loopLeft      <= 4'h0;
            frame         <= '0;
            formatError   <= 1'b0;
            driveRateCode <= frame_decoder_pkg::RATE_RESET;
            pointTarget   <= 8'h00;
            playing       <= 1'b0;
        end
        else
        begin
            case (state)
                IDLE:
                begin
                    playing <= 1'b0;
                    if (startReq)
                    begin
                        ptr           <= seqStart;
                        formatError   <= 1'b0;
                        driveRateCode <= trackedRate;
                        playing       <= 1'b1;
                        state         <= FETCH1;
                    end
                end
                FETCH1:
                begin
                    frame.gain     <= curByte[6:5];
                    frame.tbase    <= curByte[4:3];
                    frame.clipIdx  <= {1'b0, curByte[2:0]};
                    frame.loopCode <= 4'h0;
                    frame.rateHere <= 1'b0;
                    ptr            <= ptr + 7'h1;
                    state          <= extFlag ? FETCH2 : SETUP;
                end
                FETCH2:
                begin
                    ptr <= ptr + 7'h1;
                    if (!extFlag)
                    begin
                        formatError <= 1'b1;
                        state       <= IDLE;
                    end
                    else
                    begin
                        frame.loopCode   <= curByte[6:3];
                        frame.rateHere   <= curByte[frame_decoder_pkg::RATE_HERE];
                        frame.rateCode   <= {curByte[frame_decoder_pkg::RATE_HI], 8'h00};
                        frame.clipIdx[3] <= curByte[frame_decoder_pkg::CLIP_HI];
                        state <= curByte[frame_decoder_pkg::RATE_HERE] ? FETCH3 : SETUP;
                    end
                end
                FETCH3:
                begin
                    frame.rateCode[7:0] <= curByte;
                    ptr                 <= ptr + 7'h1;
                    state               <= SETUP;
                end
                SETUP:
                begin
                    if (frame.rateHere)
                    begin
                        driveRateCode <= frame.rateCode;
                        state         <= DIVIDE;
                    end
                    else
                        state <= LOAD;
                end
                DIVIDE:
                    if (divCount == 5'(frame_decoder_pkg::DIV_STEPS))
                        state <= LOAD;
                LOAD:
                begin
                    pointPtr <= clipFirst;
                    loopLeft <= frame.loopCode;
                    state    <= POINT;
                end
                POINT:
                begin
                    pointTarget <= silent ? 8'h00
                                 : {pointByte[3:0], pointByte[3:0]} >> (frame.gain);
                    state <= WAIT;
                end
                WAIT:
                    if (shapeDone)
                    begin
                        if (!silent && pointPtr != clipLast)
                        begin
                            pointPtr <= pointPtr + 7'h1;
                            state    <= POINT;
                        end
                        else if (loopLeft != 4'h0)
                        begin
                            loopLeft <= loopLeft - 4'h1;
                            pointPtr <= (silent || clipFirst == clipLast) ? clipFirst
                                      : 7'(clipFirst + 7'h1);
                            state    <= POINT;
                        end
                        else
                            state <= seqDone ? IDLE : FETCH1;
                    end
                default:
                    state <= IDLE;
            endcase
        end
    end
    // =====================================================
    // restoring divider: period in microseconds = 1e6 / rate in hz
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            quot                 <= 20'h0;
            rem                  <= 11'h0;
            divisor              <= 11'h1;
            divCount             <= 5'h0;
            activePeriodReadback <= frame_decoder_pkg::PERIOD_RESET;
        end
        else if (state == SETUP)
        begin
            quot     <= frame_decoder_pkg::US_PER_S;
            rem      <= 11'h0;
            divisor  <= {1'b0, rate_hz(frame.rateCode)};
            divCount <= 5'h0;
        end
        else if (state == DIVIDE)
        begin
            if (divCount == 5'(frame_decoder_pkg::DIV_STEPS))
                activePeriodReadback <= quot;
            else
            begin
                rem      <= fits ? 11'(remShift - {1'b0, divisor}) : remShift[10:0];
                quot     <= {quot[18:0], fits};
                divCount <= divCount + 5'h1;
            end
        end
    end
    // output level follows the shaper one cycle later
    always_ff @(posedge clk)
    begin
        if (srst)
            driveLevel <= 8'h00;
        else
            driveLevel <= shapedLevel;
    end
    // =====================================================
    timebase_ticker #(.BASE_CYC(BASE_CYC)) u_ticker (
        .clk  (clk),
        .srst (srst),
        .run  (state == WAIT),
        .fast (fastStepUnitSelect),
        .sel  (frame.tbase),
        .tick (tick)
    );
    level_shaper u_shaper (
        .clk    (clk),
        .srst   (srst),
        .load   (startPoint),
        .target (silent ? 8'h00 : {pointByte[3:0], pointByte[3:0]} >> (frame.gain)),
        .ramp   (silent ? 1'b0 : pointByte[7]),
        .dur    (silent ? frame_decoder_pkg::SILENT_DUR : pointByte[6:4]),
        .tick   (tick),
        .level  (shapedLevel),
        .done   (shapeDone)
    );
    // =====================================================
    // checks
    property p_single_byte;
        @(posedge clk) disable iff (srst) (state == FETCH1 && !extFlag) |=> state == SETUP;
    endproperty
    a_single_byte: assert property (p_single_byte) else $error("one-byte frame fetched more");
    property p_second_ext;
        @(posedge clk) disable iff (srst)
        (state == FETCH2 && !extFlag) |=> (formatError && state == IDLE);
    endproperty
    a_second_ext: assert property (p_second_ext) else $error("bad second byte accepted");
    property p_third;
        @(posedge clk) disable iff (srst)
        (state == FETCH2 && extFlag && curByte[2]) |=> state == FETCH3 ##1 state == SETUP;
    endproperty
    a_third: assert property (p_third) else $error("third byte not fetched");
    property p_defaults;
        @(posedge clk) disable iff (srst)
        (state == FETCH1 && !extFlag) |=> (frame.clipIdx[3] == 1'b0 && frame.loopCode == 4'h0);
    endproperty
    a_defaults: assert property (p_defaults) else $error("absent byte two not defaulted");
    property p_gain;
        @(posedge clk) disable iff (srst) (state == POINT && !silent) |=>
        pointTarget == ({$past(pointByte[3:0]), $past(pointByte[3:0])} >> $past(frame.gain));
    endproperty
    a_gain: assert property (p_gain) else $error("gain not applied");
    property p_clamp;
        @(posedge clk) disable iff (srst) (state == DIVIDE) |-> divisor >= 11'h019;
    endproperty
    a_clamp: assert property (p_clamp) else $error("rate below floor");
    property p_silent;
        @(posedge clk) disable iff (srst) (state == POINT && silent) |=> pointTarget == 8'h00;
    endproperty
    a_silent: assert property (p_silent) else $error("silent clip not silent");
    property p_no_start;
        @(posedge clk) disable iff (srst) (state == IDLE && !startReq) |=> state == IDLE;
    endproperty
    a_no_start: assert property (p_no_start) else $error("play without sequence");
    property p_keep_rate;
        @(posedge clk) disable iff (srst)
        (state == SETUP && !frame.rateHere) |=> $stable(driveRateCode);
    endproperty
    a_keep_rate: assert property (p_keep_rate) else $error("rate changed w/o byte");
    property p_period;
        @(posedge clk) disable iff (srst) (state == SETUP && frame.rateHere) |->
        ##[21:23] activePeriodReadback == 20'(frame_decoder_pkg::US_PER_S / divisor);
    endproperty
    a_period: assert property (p_period) else $error("period readback wrong");
    c_three_byte: cover property (@(posedge clk) state == FETCH3);
    c_repeat: cover property (@(posedge clk) state == WAIT && shapeDone && loopLeft != 4'h0);
    c_error: cover property (@(posedge clk) $rose(formatError));
endmodule : frame_sequence_decoder

// >>> dv/rate_source_model.sv
`timescale 1ns/10ps
// =====================================================
// far-side resonance tracker: hands over a steady tracked rate code
module rate_source_model #(
    parameter logic [8:0] TRACKED = 9'h064
) (
    input  wire logic  clk,
    output logic [8:0] trackedRate
);
    // a steady value keeps the expected rate of rate-less frames simple
    always_ff @(posedge clk)
        trackedRate <= TRACKED;
endmodule : rate_source_model

// >>> dv/haptic_frame_sequence_decoder_test.sv
`timescale 1ns/10ps
// =====================================================
// bench: memory image loaded over avalon, sequences started, results read
module haptic_frame_sequence_decoder_test;
    logic        clk = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0;
    logic [7:0]  address = 8'h00, driveLevel, peak, lastLevel;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic        waitrequest, playing, halfSeen;
    logic [8:0]  driveRateCode, trackedRate;
    int          miscompares = 0, n_compared = 0, playCycles;
    // clip 1 at byte 0, clip 2 (ramp then step) at bytes 1..2; sequences from byte 10 on
    logic [7:0]  img [0:22] = '{8'h1f, 8'haf, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h81, 8'h86, 8'h10, 8'h29, 8'h81, 8'h06, 8'h81,
        8'h84, 8'h05, 8'h49, 8'h00, 8'h82, 8'h88};
    always #50 clk = ~clk;
    rate_source_model i_rate_source_model (.clk(clk), .trackedRate(trackedRate));
    frame_sequence_decoder #(.BASE_CYC(4)) i_frame_sequence_decoder (.clk(clk),
        .srst(srst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .trackedRate(trackedRate), .driveLevel(driveLevel),
        .driveRateCode(driveRateCode), .playing(playing));
    // =====================================================
    task automatic finish_test();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // request held until waitrequest is sampled low, then released
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n == 50)
        begin
            miscompares++;
            finish_test();
        end
    endtask : bus
    // start happens one edge after acceptance; cycles with playing high are counted,
    // so a wrong timebase or restart point shows up as a wrong length
    task automatic play(input logic [6:0] first, input logic [6:0] last, input logic fast);
        int n;
        bus(1'b1, frame_decoder_pkg::OFS_SEQ, {16'h0, 1'b0, last, 1'b0, first});
        bus(1'b1, frame_decoder_pkg::OFS_CTRL, {30'h0, fast, 1'b1});
        peak = 8'h00;
        halfSeen = 1'b0;
        playCycles = 0;
        @(posedge clk);
        for (n = 0; n < 3000; n++)
        begin
            @(posedge clk);
            if (playing !== 1'b1) break;
            playCycles++;
            lastLevel = driveLevel;
            if (driveLevel > peak) peak = driveLevel;
            if (driveLevel == 8'h7f) halfSeen = 1'b1;
        end
        if (n == 3000)
        begin
            miscompares++;
            finish_test();
        end
    endtask : play
    // =====================================================
    initial
    begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        bus(1'b0, frame_decoder_pkg::OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h3f, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 23; i++)
            bus(1'b1, frame_decoder_pkg::OFS_MEM + 8'(i), {24'h0, img[i]});
        bus(1'b1, frame_decoder_pkg::OFS_CLIPBASE, 32'h0);
        bus(1'b1, frame_decoder_pkg::OFS_CLIPEND + 8'h01, 32'h0);
        bus(1'b1, frame_decoder_pkg::OFS_CLIPEND + 8'h02, 32'h2);
        $display("test done: load");
        play(7'd10, 7'd13, 1'b0);
        chk({24'h0, peak}, 32'hff);
        bus(1'b0, frame_decoder_pkg::OFS_RATE, 32'h0);
        chk(rd, 32'h110);
        bus(1'b0, frame_decoder_pkg::OFS_PERIOD, 32'h0);
        chk(rd, 32'h72e);
        $display("test done: three byte frame");
        play(7'd14, 7'd15, 1'b0);
        bus(1'b0, frame_decoder_pkg::OFS_STATUS, 32'h0);
        chk(rd & 32'h3, 32'h2);
        $display("test done: format error");
        play(7'd16, 7'd18, 1'b0);
        bus(1'b0, frame_decoder_pkg::OFS_PERIOD, 32'h0);
        chk(rd, 32'h9c40);
        $display("test done: low rate clamp");
        play(7'd19, 7'd19, 1'b0);
        chk({23'h0, driveRateCode}, 32'h064);
        chk(playCycles, 32'h46);
        chk({24'h0, lastLevel}, 32'h3f);
        $display("test done: kept rate");
        // silent frame, then clip 2 played once on the fast timebase, its one repeat restarting at the step at byte 2
        play(7'h14, 7'h16, 1'b1);
        chk(playCycles, 32'h28);
        chk({31'h0, halfSeen}, 32'h1);
        $display("test done: fast repeat ramp");
        finish_test();
    end
endmodule : haptic_frame_sequence_decoder_test
